// ==== inc/lsc_pkg.sv ====
// Package with register map, field layout and timing constants of the light sensor control block.
package lsc_pkg;

	// Register indices on the two-wire bus.
	localparam logic [2:0] LSC_IDX_COMMAND   = 3'h0;
	localparam logic [2:0] LSC_IDX_CONTROL   = 3'h1;
	localparam logic [2:0] LSC_IDX_UPPER_THR = 3'h2;
	localparam logic [2:0] LSC_IDX_LOWER_THR = 3'h3;
	localparam logic [2:0] LSC_IDX_RES_LOW   = 3'h4;
	localparam logic [2:0] LSC_IDX_RES_HIGH  = 3'h5;
	localparam logic [2:0] LSC_IDX_CNT_LOW   = 3'h6;
	localparam logic [2:0] LSC_IDX_CNT_HIGH  = 3'h7;

	// Pointer byte special bits and control field positions.
	localparam int LSC_PTR_SYNC_BIT    = 7;
	localparam int LSC_PTR_CLEAR_BIT   = 6;
	localparam int LSC_CTRL_FLAG_BIT   = 5;
	localparam int LSC_CTRL_RANGE_HI   = 3;
	localparam int LSC_CTRL_RANGE_LO   = 2;
	localparam int LSC_CTRL_PERSIST_HI = 1;
	localparam int LSC_CTRL_PERSIST_LO = 0;

	// Reset values, threshold low byte and timer saturation value.
	localparam logic [7:0]  LSC_CTRL_RESET  = 8'h00;
	localparam logic [7:0]  LSC_UPPER_RESET = 8'hff;
	localparam logic [7:0]  LSC_LOWER_RESET = 8'h00;
	localparam logic [7:0]  LSC_THR_LSB     = 8'h00;
	localparam logic [15:0] LSC_ZERO16      = 16'h0000;
	localparam logic [15:0] LSC_MAX16       = 16'hffff;

	// Integration lengths per width code and persistence counts per code.
	localparam logic [16:0] LSC_CYC_W0 = 17'h1_0000;
	localparam logic [16:0] LSC_CYC_W1 = 17'h0_1000;
	localparam logic [16:0] LSC_CYC_W2 = 17'h0_0100;
	localparam logic [16:0] LSC_CYC_W3 = 17'h0_0010;
	localparam logic [4:0]  LSC_PERSIST_0 = 5'h01;
	localparam logic [4:0]  LSC_PERSIST_1 = 5'h04;
	localparam logic [4:0]  LSC_PERSIST_2 = 5'h08;
	localparam logic [4:0]  LSC_PERSIST_3 = 5'h10;

	// Oscillator rates and core clock rate in hertz.
	localparam int          LSC_CORE_CLK_HZ = 10_000_000;
	localparam int          LSC_OSC_SLOW_HZ = 327_000;
	localparam int          LSC_OSC_FAST_HZ = 655_000;
	localparam logic [24:0] LSC_ACC_CLK     = 25'(LSC_CORE_CLK_HZ);
	localparam logic [24:0] LSC_ACC_SLOW    = 25'(LSC_OSC_SLOW_HZ);
	localparam logic [24:0] LSC_ACC_FAST    = 25'(LSC_OSC_FAST_HZ);

	// Photodiode mode code that runs the two diodes in sequence.
	localparam logic [1:0] LSC_MODE_DIFF = 2'b10;

	// Serial slave states.
	typedef enum logic [2:0] {
		LSC_S_IDLE      = 3'b000,
		LSC_S_ADDR      = 3'b001,
		LSC_S_ADDR_ACK  = 3'b010,
		LSC_S_WRITE     = 3'b011,
		LSC_S_WRITE_ACK = 3'b100,
		LSC_S_READ      = 3'b101,
		LSC_S_READ_ACK  = 3'b110
	} lsc_state_type;

endpackage

// ==== core/lsc_light_sensor_ctrl.sv ====
// Control, threshold, result and timer registers of the light sensor behind its two-wire port.
//
// Function
// - Control register at index 1 is readable and writable by the host.
// - Interrupt status bit 5 sets on a threshold trigger, else stays zero.
// - Host writing zero to the status bit clears it.
// - Bits 3:2 select ranges one to four for codes 00 to 11.
// - Oscillator runs 327 kHz for ranges one and two, 655 kHz otherwise.
// - Pin and flag assert after m consecutive out-of-window integration cycles.
// - Bits 1:0 give m as 1, 4, 8 or 16.
// - Index 2 is upper threshold high byte, low byte zero, reset FF.
// - Index 3 is lower threshold high byte, low byte zero, reset 00.
// - Result registers update at the end of every integration cycle, and of every second one in difference mode.
// - Result low byte at index 4, high byte at index 5.
// - Timer count low byte at index 6, high byte at 7.
// - Timer counter increments once per oscillator cycle while integrating.
// - Period end captures the timer count together with that period's result.
// - Internal timing limits the result to 2 to the n minus one counts outside difference mode.
// - Width bits 1:0 select 65536, 4096, 256 or 16 cycles.
// - Command bit 5 zero selects internal timing, one external timing.
// - Each sync command after the first ends one integration and starts the next; the first only starts one.
// - A write with pointer bit 6 set clears the interrupt.
`timescale 1ns/1ns
`default_nettype none

module lsc_light_sensor_ctrl
	import lsc_pkg::*;
#(
	parameter logic [4:0] DEV_ADDR_BASE = 5'h0a // Arbitrary value.
) (
	// Clock and reset.
	input  wire logic        core_clk,
	input  wire logic        rst,
	// Two-wire serial port and address pins.
	input  wire logic        scl_in,
	input  wire logic        sda_in,
	output logic             sda_out,
	output logic             sda_oe_n,
	input  wire logic [1:0]  addr_pin,
	// Command register fields.
	input  wire logic        cmd_enable,
	input  wire logic        cmd_power_down,
	input  wire logic        cmd_ext_timing,
	input  wire logic [1:0]  cmd_mode,
	input  wire logic [1:0]  cmd_width,
	// Converter core.
	input  wire logic [15:0] conv_data,
	output logic             osc_tick,
	output logic             osc_fast,
	output logic             diode_select,
	output logic             integ_end,
	// Interrupt pin.
	output logic             int_n
);

	logic [2:0]    scl_sync_r;
	logic [2:0]    sda_sync_r;
	logic [3:0]    addr_sync_r;
	logic          scl_rise;
	logic          scl_fall;
	logic          bus_start;
	logic          bus_stop;
	lsc_state_type state_r;
	logic [7:0]    shift_r;
	logic [3:0]    bit_cnt_r;
	logic          first_byte_r;
	logic          read_dir_r;
	logic [2:0]    ptr_r;
	logic [7:0]    rdata;
	logic          wr_strobe;
	logic          ptr_strobe;
	logic          sync_cmd;
	logic          clear_cmd;
	logic [7:0]    ctrl_r;
	logic [7:0]    upper_thr_r;
	logic [7:0]    lower_thr_r;
	logic [15:0]   result_r;
	logic [15:0]   count_out_r;
	logic          flag_r;
	logic [24:0]   acc_r;
	logic [24:0]   acc_sum;
	logic [16:0]   timer_r;
	logic [16:0]   limit;
	logic          running_r;
	logic          ext_started_r;
	logic          phase_r;
	logic [15:0]   first_data_r;
	logic          period_end;
	logic          reading_done;
	logic [15:0]   reading;
	logic [15:0]   clamped;
	logic [4:0]    persist_m;
	logic [4:0]    persist_cnt_r;
	logic          out_of_window;
	logic          trigger;
	logic          active;
	logic [15:0]   timer_sat;

	// Pin synchronisers; only the second and third stages are examined.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			scl_sync_r  <= 3'b111;
			sda_sync_r  <= 3'b111;
			addr_sync_r <= 4'h0;
		end else begin
			scl_sync_r  <= {scl_sync_r[1:0], scl_in};
			sda_sync_r  <= {sda_sync_r[1:0], sda_in};
			addr_sync_r <= {addr_sync_r[1:0], addr_pin};
		end
	end

	assign scl_rise  = scl_sync_r[1] & ~scl_sync_r[2];
	assign scl_fall  = ~scl_sync_r[1] & scl_sync_r[2];
	assign bus_start = scl_sync_r[1] & ~sda_sync_r[1] & sda_sync_r[2];
	assign bus_stop  = scl_sync_r[1] & sda_sync_r[1] & ~sda_sync_r[2];

	// Byte-level serial slave.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			state_r      <= LSC_S_IDLE;
			shift_r      <= 8'h00;
			bit_cnt_r    <= 4'h0;
			first_byte_r <= 1'b0;
			read_dir_r   <= 1'b0;
			ptr_r        <= LSC_IDX_COMMAND;
		end else if (bus_start) begin
			state_r   <= LSC_S_ADDR;
			bit_cnt_r <= 4'h0;
		end else if (bus_stop) begin
			state_r <= LSC_S_IDLE;
		end else if (scl_rise) begin
			if (state_r == LSC_S_ADDR || state_r == LSC_S_WRITE) begin
				shift_r   <= {shift_r[6:0], sda_sync_r[1]};
				bit_cnt_r <= bit_cnt_r + 4'h1;
			end else if (state_r == LSC_S_READ_ACK) begin
				read_dir_r <= ~sda_sync_r[1];
			end
		end else if (scl_fall) begin
			unique case (state_r)
				LSC_S_IDLE: begin
					state_r <= LSC_S_IDLE;
				end
				LSC_S_ADDR: begin
					if (bit_cnt_r[3]) begin
						if (shift_r[7:1] == {DEV_ADDR_BASE, addr_sync_r[3:2]}) begin
							state_r    <= LSC_S_ADDR_ACK;
							read_dir_r <= shift_r[0];
						end else begin
							state_r <= LSC_S_IDLE;
						end
					end
				end
				LSC_S_ADDR_ACK: begin
					bit_cnt_r    <= 4'h0;
					first_byte_r <= 1'b1;
					if (read_dir_r) begin
						state_r <= LSC_S_READ;
						shift_r <= rdata;
					end else begin
						state_r <= LSC_S_WRITE;
					end
				end
				LSC_S_WRITE: begin
					if (bit_cnt_r[3]) begin
						state_r <= LSC_S_WRITE_ACK;
						if (first_byte_r) begin
							ptr_r <= shift_r[2:0];
						end else begin
							ptr_r <= ptr_r + 3'h1;
						end
					end
				end
				LSC_S_WRITE_ACK: begin
					state_r      <= LSC_S_WRITE;
					bit_cnt_r    <= 4'h0;
					first_byte_r <= 1'b0;
				end
				LSC_S_READ: begin
					if (bit_cnt_r == 4'h7) begin
						state_r <= LSC_S_READ_ACK;
						ptr_r   <= ptr_r + 3'h1;
					end else begin
						shift_r   <= {shift_r[6:0], 1'b1};
						bit_cnt_r <= bit_cnt_r + 4'h1;
					end
				end
				LSC_S_READ_ACK: begin
					bit_cnt_r <= 4'h0;
					if (read_dir_r) begin
						state_r <= LSC_S_READ;
						shift_r <= rdata;
					end else begin
						state_r <= LSC_S_IDLE;
					end
				end
				default: begin
					state_r <= LSC_S_IDLE;
				end
			endcase
		end
	end

	assign ptr_strobe = scl_fall && state_r == LSC_S_WRITE && bit_cnt_r[3] && first_byte_r;
	assign wr_strobe  = scl_fall && state_r == LSC_S_WRITE && bit_cnt_r[3] && !first_byte_r;
	assign sync_cmd   = ptr_strobe & shift_r[LSC_PTR_SYNC_BIT];
	assign clear_cmd  = ptr_strobe & shift_r[LSC_PTR_CLEAR_BIT];

	// Open-drain data line: enable low pulls the line low.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			sda_oe_n <= 1'b1;
		end else begin
			sda_oe_n <= !(state_r == LSC_S_ADDR_ACK || state_r == LSC_S_WRITE_ACK ||
				(state_r == LSC_S_READ && !shift_r[7]));
		end
	end

	assign sda_out = 1'b0;

	// Read data selection.
	always_comb begin
		unique case (ptr_r)
			LSC_IDX_CONTROL:   rdata = {ctrl_r[7:6], flag_r, ctrl_r[4:0]};
			LSC_IDX_UPPER_THR: rdata = upper_thr_r;
			LSC_IDX_LOWER_THR: rdata = lower_thr_r;
			LSC_IDX_RES_LOW:   rdata = result_r[7:0];
			LSC_IDX_RES_HIGH:  rdata = result_r[15:8];
			LSC_IDX_CNT_LOW:   rdata = count_out_r[7:0];
			LSC_IDX_CNT_HIGH:  rdata = count_out_r[15:8];
			default:           rdata = 8'h00;
		endcase
	end

	// Writable registers.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			ctrl_r      <= LSC_CTRL_RESET;
			upper_thr_r <= LSC_UPPER_RESET;
			lower_thr_r <= LSC_LOWER_RESET;
		end else if (wr_strobe) begin
			if (ptr_r == LSC_IDX_CONTROL) begin
				ctrl_r <= shift_r;
			end
			if (ptr_r == LSC_IDX_UPPER_THR) begin
				upper_thr_r <= shift_r;
			end
			if (ptr_r == LSC_IDX_LOWER_THR) begin
				lower_thr_r <= shift_r;
			end
		end
	end

	// Oscillator rate follows the range field.
	assign osc_fast = ctrl_r[LSC_CTRL_RANGE_HI];
	assign acc_sum  = acc_r + (osc_fast ? LSC_ACC_FAST : LSC_ACC_SLOW);

	always_ff @(posedge core_clk) begin
		if (rst) begin
			acc_r    <= 25'h000_0000;
			osc_tick <= 1'b0;
		end else if (acc_sum >= LSC_ACC_CLK) begin
			acc_r    <= acc_sum - LSC_ACC_CLK;
			osc_tick <= 1'b1;
		end else begin
			acc_r    <= acc_sum;
			osc_tick <= 1'b0;
		end
	end

	// Integration length from the width field.
	always_comb begin
		unique case (cmd_width)
			2'b00: limit = LSC_CYC_W0;
			2'b01: limit = LSC_CYC_W1;
			2'b10: limit = LSC_CYC_W2;
			2'b11: limit = LSC_CYC_W3;
		endcase
	end

	assign active     = cmd_enable & ~cmd_power_down;
	assign period_end = active && (cmd_ext_timing ? (sync_cmd && ext_started_r)
		: (osc_tick && running_r && timer_r + 17'h1 >= limit));
	assign integ_end  = period_end;
	assign timer_sat  = timer_r[16] ? LSC_MAX16 : timer_r[15:0];

	// Integration timer and period sequencing.
	always_ff @(posedge core_clk) begin
		if (rst || !active) begin
			timer_r       <= 17'h0_0000;
			running_r     <= 1'b0;
			ext_started_r <= 1'b0;
			phase_r       <= 1'b0;
		end else if (period_end) begin
			timer_r <= 17'h0_0000;
			phase_r <= (cmd_mode == LSC_MODE_DIFF) ? ~phase_r : 1'b0;
		end else begin
			running_r <= cmd_ext_timing ? ext_started_r : 1'b1;
			if (cmd_ext_timing && sync_cmd) begin
				ext_started_r <= 1'b1;
				timer_r       <= 17'h0_0000;
			end else if (osc_tick && (running_r || ext_started_r) && timer_r != LSC_CYC_W0) begin
				timer_r <= timer_r + 17'h1;
			end
		end
	end

	assign diode_select = phase_r;

	// Internal timing clamps to full scale of the selected width.
	assign clamped = (!cmd_ext_timing && {1'b0, conv_data} >= limit) ?
		16'(limit - 17'h1) : conv_data;
	assign reading_done = period_end && !(cmd_mode == LSC_MODE_DIFF && !phase_r);
	assign reading      = (cmd_mode == LSC_MODE_DIFF) ? first_data_r - clamped : clamped;

	// Result and timer capture.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			result_r     <= LSC_ZERO16;
			count_out_r  <= LSC_ZERO16;
			first_data_r <= LSC_ZERO16;
		end else if (period_end) begin
			if (!reading_done) begin
				first_data_r <= clamped;
			end else begin
				result_r    <= reading;
				count_out_r <= cmd_ext_timing ? timer_sat + 16'(osc_tick) : timer_sat;
			end
		end
	end

	// Window compare and persistence.
	always_comb begin
		unique case (ctrl_r[LSC_CTRL_PERSIST_HI:LSC_CTRL_PERSIST_LO])
			2'b00: persist_m = LSC_PERSIST_0;
			2'b01: persist_m = LSC_PERSIST_1;
			2'b10: persist_m = LSC_PERSIST_2;
			2'b11: persist_m = LSC_PERSIST_3;
		endcase
	end

	assign out_of_window = (reading > {upper_thr_r, LSC_THR_LSB}) ||
		(reading < {lower_thr_r, LSC_THR_LSB});
	assign trigger = reading_done && out_of_window && (persist_cnt_r + 5'h1 >= persist_m);

	always_ff @(posedge core_clk) begin
		if (rst) begin
			persist_cnt_r <= 5'h00;
		end else if (reading_done) begin
			if (!out_of_window) begin
				persist_cnt_r <= 5'h00;
			end else if (persist_cnt_r != LSC_PERSIST_3) begin
				persist_cnt_r <= persist_cnt_r + 5'h1;
			end
		end
	end

	// Interrupt flag; a trigger in the clearing cycle wins.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			flag_r <= 1'b0;
		end else if (trigger) begin
			flag_r <= 1'b1;
		end else if (clear_cmd || (wr_strobe && ptr_r == LSC_IDX_CONTROL &&
			!shift_r[LSC_CTRL_FLAG_BIT])) begin
			flag_r <= 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			int_n <= 1'b1;
		end else begin
			int_n <= ~(flag_r | trigger);
		end
	end

endmodule

`default_nettype wire

// ==== test/lsc_light_sensor_ctrl_props.sv ====
// Checker of the light sensor control block ports.
`timescale 1ns/1ns
`default_nettype none
module lsc_light_sensor_ctrl_props
	import lsc_pkg::*;
(
	// Clock and reset.
	input wire logic        core_clk,
	input wire logic        rst,
	// Bus pins.
	input wire logic        scl_in,
	input wire logic        sda_in,
	input wire logic        sda_out,
	input wire logic        sda_oe_n,
	input wire logic [1:0]  addr_pin,
	// Command fields.
	input wire logic        cmd_enable,
	input wire logic        cmd_power_down,
	input wire logic        cmd_ext_timing,
	input wire logic [1:0]  cmd_mode,
	input wire logic [1:0]  cmd_width,
	// Converter and interrupt.
	input wire logic [15:0] conv_data,
	input wire logic        osc_tick,
	input wire logic        osc_fast,
	input wire logic        diode_select,
	input wire logic        integ_end,
	input wire logic        int_n
);
	logic [4:0] ticks_r;
	logic       valid_r;
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	// Counts oscillator ticks since the last period end.
	always_ff @(posedge core_clk) begin
		if (rst || integ_end)
			ticks_r <= 5'h00;
		else if (osc_tick)
			ticks_r <= ticks_r + 5'h01;
	end
	// Marks that a full internal period is being counted.
	always_ff @(posedge core_clk) begin
		valid_r <= !rst && !cmd_ext_timing && (valid_r || integ_end);
	end
	AST_RESET_QUIET: assert property (disable iff (1'b0) rst |=> int_n && sda_oe_n && !integ_end)
		else $error("outputs not idle after reset");
	AST_TICK_GAP: assert property (osc_tick |=> !osc_tick [*8])
		else $error("oscillator ticks too close");
	AST_TICK_RATE: assert property (osc_tick |-> ##[15:31] osc_tick)
		else $error("oscillator tick missing");
	AST_END_ON_TICK: assert property ((integ_end && !cmd_ext_timing) |-> osc_tick)
		else $error("internal period end off a tick");
	AST_PERIOD_LEN: assert property ((integ_end && valid_r && !cmd_ext_timing && cmd_width == 2'b11)
		|-> ticks_r == 5'h0f)
		else $error("internal period length wrong");
	AST_PIN_FALL: assert property ($fell(int_n) |-> $past(integ_end))
		else $error("interrupt pin fell without a reading");
	AST_PIN_RISE: assert property ($rose(int_n) |-> ##[0:8] !sda_oe_n)
		else $error("interrupt pin released without a host write");
	AST_SDA_SCL_LOW: assert property ($changed(sda_oe_n) |-> !scl_in)
		else $error("data line changed while clock high");
	cover property (integ_end && cmd_ext_timing);
	cover property ($fell(int_n));
	cover property (osc_tick && osc_fast);
	cover property ($rose(diode_select));
endmodule
bind lsc_light_sensor_ctrl lsc_light_sensor_ctrl_props u_props (
	.core_clk(core_clk), .rst(rst), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
	.sda_oe_n(sda_oe_n), .addr_pin(addr_pin), .cmd_enable(cmd_enable),
	.cmd_power_down(cmd_power_down), .cmd_ext_timing(cmd_ext_timing), .cmd_mode(cmd_mode),
	.cmd_width(cmd_width), .conv_data(conv_data), .osc_tick(osc_tick), .osc_fast(osc_fast),
	.diode_select(diode_select), .integ_end(integ_end), .int_n(int_n));
`default_nettype wire

// ==== test/lsc_i2c_host.sv ====
// Behavioural two-wire bus host that reaches the sensor registers.
`timescale 1ns/1ns
`default_nettype none
module lsc_i2c_host #(
	parameter logic [6:0] DEV_ADDR = 7'h29,
	parameter int         PHASE    = 6
) (
	// Clock.
	input  wire logic core_clk,
	// Bus lines; the data line has a pull-up.
	input  wire logic sda_line,
	output var logic  scl,
	output var logic  sda_pull
);
	int nack_count;
	initial begin
		scl = 1'b1;
		sda_pull = 1'b0;
		nack_count = 0;
	end
	task automatic tk();
		repeat (PHASE) @(posedge core_clk);
		#1;
	endtask
	task automatic bit_io(input logic b, output logic r);
		sda_pull = !b;
		tk();
		scl = 1'b1;
		tk();
		r = sda_line;
		scl = 1'b0;
		tk();
	endtask
	task automatic xbyte(input logic [7:0] v, input logic rd, input logic last, output logic [7:0] r);
		logic a;
		for (int i = 7; i >= 0; i--)
			bit_io(v[i], r[i]);
		bit_io(rd ? last : 1'b1, a);
		if (!rd && a !== 1'b0)
			nack_count++;
	endtask
	task automatic start();
		sda_pull = 1'b0;
		scl = 1'b1;
		tk();
		sda_pull = 1'b1;
		tk();
		scl = 1'b0;
		tk();
	endtask
	task automatic stop();
		sda_pull = 1'b1;
		tk();
		scl = 1'b1;
		tk();
		sda_pull = 1'b0;
		tk();
	endtask
	task automatic wr(input logic [7:0] p, input logic [7:0] d, input logic has_d);
		logic [7:0] r;
		start();
		xbyte({DEV_ADDR, 1'b0}, 1'b0, 1'b0, r);
		xbyte(p, 1'b0, 1'b0, r);
		if (has_d)
			xbyte(d, 1'b0, 1'b0, r);
		stop();
	endtask
	task automatic rd(input logic [7:0] p, input int n, output logic [7:0] q [8]);
		logic [7:0] r;
		wr(p, 8'h00, 1'b0);
		start();
		xbyte({DEV_ADDR, 1'b1}, 1'b0, 1'b0, r);
		for (int i = 0; i < n; i++)
			xbyte(8'hff, 1'b1, i == n - 1, q[i]);
		stop();
	endtask
endmodule
`default_nettype wire

// ==== test/lsc_light_sensor_ctrl_tb.sv ====
// Self-checking testbench of the light sensor control block.
`timescale 1ns/1ns
`default_nettype none
module lsc_light_sensor_ctrl_tb import lsc_pkg::*; ();
	logic        core_clk = 1'b0;
	logic        rst = 1'b1;
	logic        ext = 1'b0;
	logic [1:0]  mode = 2'b00;
	logic [15:0] conv = 16'h0000;
	logic        scl, pull, sda, sda_out, sda_oe_n, osc_tick, osc_fast, diode_select;
	logic        integ_end, int_n;
	logic [31:0] seed = 32'h0000_0062;
	logic [7:0]  q [8];
	logic [4:0]  m_tab [4] = '{5'h01, 5'h04, 5'h08, 5'h10};
	int          failures = 0;
	int          check_count = 0;
	always #50 core_clk = ~core_clk;
	assign sda = !pull && (sda_oe_n || sda_out);
	lsc_light_sensor_ctrl dut (.core_clk(core_clk), .rst(rst), .scl_in(scl), .sda_in(sda),
		.sda_out(sda_out), .sda_oe_n(sda_oe_n), .addr_pin(2'b01), .cmd_enable(1'b1),
		.cmd_power_down(1'b0), .cmd_ext_timing(ext), .cmd_mode(mode), .cmd_width(2'b11),
		.conv_data(conv), .osc_tick(osc_tick), .osc_fast(osc_fast),
		.diode_select(diode_select), .integ_end(integ_end), .int_n(int_n));
	lsc_i2c_host #(.DEV_ADDR(7'h29)) host (.core_clk(core_clk), .sda_line(sda), .scl(scl),
		.sda_pull(pull));
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	function automatic logic [15:0] clamp4(input logic [15:0] v);
		return (v > 16'h000f) ? 16'h000f : v;
	endfunction
	function automatic int ticks_of(input int span, input logic fast);
		return fast ? span * 131 / 2000 : span * 327 / 10000;
	endfunction
	task automatic step(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		check_count++;
		if (g !== e) begin
			failures++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chk_near(input string nm, input int e, input logic [15:0] g, input int tol);
		check_count++;
		if ((g >= e - tol && g <= e + tol) !== 1'b1) begin
			failures++;
			$display("BAD %s expected %0d seen %0d", nm, e, g);
		end
	endtask
	task automatic wait_end();
		int k;
		step(1);
		for (k = 0; k < 600 && integ_end !== 1'b1; k++)
			step(1);
		chk("period end", 16'h0001, 16'(k < 600));
	endtask
	task automatic final_report();
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial begin
		logic [31:0] r;
		logic [15:0] v, n;
		int          i, m;
		time         t0;
		step(4);
		rst = 1'b0;
		step(3);
		host.rd(8'h00, 4, q);
		chk("cmd idx", 16'h0000, q[0]);
		chk("control", 16'h0000, q[1]);
		chk("upper", 16'h00ff, q[2]);
		chk("lower", 16'h0000, q[3]);
		$display("test reset values done");
		for (int c = 0; c < 4; c++) begin
			r = xs();
			host.wr(8'h01, {4'h0, 2'(c), r[1:0]}, 1'b1);
			host.rd(8'h01, 1, q);
			chk("control", {8'h00, 4'h0, 2'(c), r[1:0]}, q[0]);
			chk("osc_fast", 16'(c / 2), osc_fast);
			n = 16'h0000;
			repeat (3000) begin
				step(1);
				n = n + {15'h0000, osc_tick};
			end
			chk_near("tick count", ticks_of(3000, c / 2), n, 2);
		end
		$display("test range done");
		host.wr(8'h02, 8'h00, 1'b1);
		for (int p = 0; p < 4; p++) begin
			conv = 16'h0000;
			host.wr(8'h01, {4'h0, 2'b11, 2'(p)}, 1'b1);
			r = xs();
			v = r[15:0] | 16'h0001;
			m = m_tab[p];
			wait_end();
			step(1);
			conv = (m == 1) ? 16'h0000 : v;
			for (i = 1; i <= 40; i++) begin
				wait_end();
				step(1);
				if (int_n === 1'b0)
					break;
				conv = (i + 1 == m) ? 16'h0000 : v;
			end
			chk("persist", 16'(2 * m), 16'(i));
			host.rd(8'h01, 1, q);
			chk("flag set", {8'h00, 6'h0b, 2'(p)}, q[0]);
			host.rd(8'h04, 2, q);
			chk("result", clamp4(v), {q[1], q[0]});
			conv = 16'h0000;
			if (p % 2 == 1)
				host.wr(8'h41, 8'h00, 1'b0);
			else
				host.wr(8'h01, {4'h0, 2'b11, 2'(p)}, 1'b1);
			step(2);
			chk("int_n", 16'h0001, int_n);
			host.rd(8'h01, 1, q);
			chk("flag clear", {8'h00, 4'h0, 2'b11, 2'(p)}, q[0]);
		end
		$display("test persistence done");
		ext = 1'b1;
		r = xs();
		conv = r[15:0];
		t0 = $time;
		host.wr(8'h81, 8'h00, 1'b0);
		step(2000);
		m = int'(($time - t0) / 100);
		host.wr(8'h81, 8'h00, 1'b0);
		host.rd(8'h04, 4, q);
		chk("ext result", r[15:0], {q[1], q[0]});
		chk_near("timer", ticks_of(m, 1'b1), {q[3], q[2]}, 3);
		// Difference mode under host timing: diode one, then diode two, then subtract.
		mode = LSC_MODE_DIFF;
		r = xs();
		conv = r[15:0];
		host.wr(8'h81, 8'h00, 1'b0);
		chk("diode_select", 16'h0001, diode_select);
		conv = r[31:16];
		host.wr(8'h81, 8'h00, 1'b0);
		chk("diode_select", 16'h0000, diode_select);
		host.rd(8'h04, 2, q);
		chk("diff result", r[15:0] - r[31:16], {q[1], q[0]});
		mode = 2'b00;
		ext = 1'b0;
		$display("test external timing done");
		chk("nacks", 16'h0000, 16'(host.nack_count));
		final_report();
	end
	initial begin
		repeat (100000) @(posedge core_clk);
		failures++;
		final_report();
	end
endmodule
`default_nettype wire
